// ---- src/tpfm_defines.svh ----
`ifndef TPFM_DEFINES_SVH
`define TPFM_DEFINES_SVH

// Register bus geometry.
`define TPFM_ADDR_W 8
`define TPFM_DATA_W 32

// Register byte offsets.
`define TPFM_CTRL_OFS 8'h00
`define TPFM_STAT_OFS 8'h04
`define TPFM_IRQ_STAT_OFS 8'h08
`define TPFM_IRQ_MASK_OFS 8'h0C

// Control register fields and reset value.
`define TPFM_CTRL_W 3
`define TPFM_CTRL_FALL_THRU 0
`define TPFM_CTRL_BBYTE 1
`define TPFM_CTRL_CBYTE 2
`define TPFM_CTRL_RST 3'h0

// Interrupt status and mask layout.
`define TPFM_IRQ_W 4
`define TPFM_IRQ_MAIL_AB 0
`define TPFM_IRQ_MAIL_CA 1
`define TPFM_IRQ_F1FULL 2
`define TPFM_IRQ_F2FULL 3
`define TPFM_IRQ_RST 4'h0

// Bus responses.
`define TPFM_RESP_OKAY 2'h0
`define TPFM_RESP_SLVERR 2'h2

// Long word packing: index of the last piece per long word.
`define TPFM_WORD_LAST 2'h1
`define TPFM_BYTE_LAST 2'h3

// Lane widths.
`define TPFM_A_W 36
`define TPFM_MAIL_W 18
`define TPFM_BYTE_W 9

`endif

// ---- src/tpfm_pkg.sv ----
package tpfm_pkg;

  typedef struct packed {
    logic chip_select_n;
    logic direction;
    logic mailbox_select;
    logic enable;
  } tpfm_porta_ctl_t;

  typedef struct packed {
    logic chip_select_n;
    logic mailbox_select;
    logic enable;
  } tpfm_port_ctl_t;

  typedef struct packed {
    logic mailbox_two_full;
    logic mailbox_one_full;
    logic portc_almost_full;
    logic porta_almost_full;
    logic porta_almost_empty;
    logic portb_almost_empty;
    logic fifo2_room;
    logic fifo1_room;
  } tpfm_flags_t;

endpackage

// ---- src/tpfm_core.sv ----
`timescale 1ns/1ps
`include "tpfm_defines.svh"

// What this block does
// - Fall-through mode: port-A input ready rises at next port-A edge after freeing read.
// - Standard mode: port-A full flag rises one port-A clock after freeing read.
// - Port-A flag update counts from the read that ends a long word.
// - Port-C full flag drops on the write completing a long word that fills FIFO2.
// - Port-C full flag rises at next port-C edge after port-A frees space.
// - Port-B almost-empty rises at next port-B edge after port-A write leaves range.
// - Port-B almost-empty drops on the last-piece read entering the range.
// - Port-A almost-empty rises at next port-A edge after port-C write.
// - Port-A updates count from the port-C write that completes a long word.
// - Port-A almost-full rises at next port-A edge after port-B read leaves range.
// - Port-C almost-full rises after port-A read; falls on long-word write.
// - Word size: mailbox A-to-B takes A bits 0-17, shown on all 18 B bits.
// - Byte size: mailbox A-to-B keeps A bits 0-8, shown on B bits 0-8.
// - Word size: mailbox C-to-A shows all 18 C bits on A bits 18-35.
// - Byte size: mailbox C-to-A keeps C bits 0-8, shown on A bits 18-26.
module tpfm_core
  import tpfm_pkg::*;
#(
  parameter int DEPTH = 256,
  parameter int AE_OFFSET = 8,
  parameter int AF_OFFSET = 8
) (
  input logic core_clk,
  input logic rst_n,
  input logic core_ce,
  input logic [`TPFM_ADDR_W-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [`TPFM_DATA_W-1:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [`TPFM_ADDR_W-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [`TPFM_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  output logic irq,
  input logic porta_clock,
  input tpfm_porta_ctl_t porta_ctl,
  input logic [`TPFM_A_W-1:0] porta_data_in,
  output logic [`TPFM_A_W-1:0] porta_data_out,
  output logic porta_data_oe,
  output logic porta_input_ready,
  output logic porta_full_flag,
  output logic porta_almost_empty,
  output logic porta_almost_full,
  input logic portb_clock,
  input tpfm_port_ctl_t portb_ctl,
  output logic [`TPFM_MAIL_W-1:0] portb_data_out,
  output logic portb_data_oe,
  output logic portb_almost_empty,
  input logic portc_clock,
  input tpfm_port_ctl_t portc_ctl,
  input logic [`TPFM_MAIL_W-1:0] portc_data_in,
  output logic portc_input_ready,
  output logic portc_full_flag,
  output logic portc_almost_full,
  output logic mailbox_one_full,
  output logic mailbox_two_full
);

  localparam int CW = $clog2(DEPTH + 1);
  localparam int SAW = 1 + $bits(tpfm_porta_ctl_t) + `TPFM_A_W;
  localparam int SBW = 1 + $bits(tpfm_port_ctl_t);
  localparam int SCW = 1 + $bits(tpfm_port_ctl_t) + `TPFM_MAIL_W;

  function automatic logic [1:0] last_piece(input logic byte_size);
    return byte_size ? `TPFM_BYTE_LAST : `TPFM_WORD_LAST;
  endfunction

  function automatic logic above_ae(input logic [CW-1:0] n);
    return n > CW'(AE_OFFSET);
  endfunction

  function automatic logic below_af(input logic [CW-1:0] n);
    return n < CW'(DEPTH - AF_OFFSET);
  endfunction

  logic [`TPFM_CTRL_W-1:0] ctrl;
  logic [`TPFM_IRQ_W-1:0] irq_status;
  logic [`TPFM_IRQ_W-1:0] irq_mask;
  logic fall_through_mode;
  logic portb_width_select;
  logic portc_width_select;

  assign fall_through_mode = ctrl[`TPFM_CTRL_FALL_THRU];
  assign portb_width_select = ctrl[`TPFM_CTRL_BBYTE];
  assign portc_width_select = ctrl[`TPFM_CTRL_CBYTE];

  // Every port pin, port clocks included, passes two flops before use; register bus pins and core_ce do not.
  logic [SAW-1:0] a_s1, a_s2;
  logic [SBW-1:0] b_s1, b_s2;
  logic [SCW-1:0] c_s1, c_s2;
  logic a_clk_q, b_clk_q, c_clk_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      a_s1 <= '0;
      a_s2 <= '0;
      b_s1 <= '0;
      b_s2 <= '0;
      c_s1 <= '0;
      c_s2 <= '0;
      a_clk_q <= 1'h0;
      b_clk_q <= 1'h0;
      c_clk_q <= 1'h0;
    end else if (core_ce) begin
      a_s1 <= {porta_clock, porta_ctl, porta_data_in};
      a_s2 <= a_s1;
      b_s1 <= {portb_clock, portb_ctl};
      b_s2 <= b_s1;
      c_s1 <= {portc_clock, portc_ctl, portc_data_in};
      c_s2 <= c_s1;
      a_clk_q <= a_s2[SAW-1];
      b_clk_q <= b_s2[SBW-1];
      c_clk_q <= c_s2[SCW-1];
    end
  end

  tpfm_porta_ctl_t a_ctl;
  tpfm_port_ctl_t b_ctl, c_ctl;
  logic [`TPFM_A_W-1:0] a_data;
  logic [`TPFM_MAIL_W-1:0] c_data;
  logic a_edge, b_edge, c_edge;

  assign a_ctl = a_s2[SAW-2:`TPFM_A_W];
  assign a_data = a_s2[`TPFM_A_W-1:0];
  assign b_ctl = b_s2[SBW-2:0];
  assign c_ctl = c_s2[SCW-2:`TPFM_MAIL_W];
  assign c_data = c_s2[`TPFM_MAIL_W-1:0];
  assign a_edge = core_ce & a_s2[SAW-1] & ~a_clk_q;
  assign b_edge = core_ce & b_s2[SBW-1] & ~b_clk_q;
  assign c_edge = core_ce & c_s2[SCW-1] & ~c_clk_q;

  logic [CW-1:0] fifo1_count, fifo2_count, fifo1_next, fifo2_next;
  logic fifo1_room, fifo2_room;
  logic [1:0] b_piece, c_piece;
  logic a_sel, a_wr1, a_rd2, a_mail_wr, a_mail_rd;
  logic b_sel, b_rd1, b_done, b_mail_rd;
  logic c_sel, c_wr2, c_done, c_mail_wr;

  // Writes against a low room flag and reads of an empty FIFO are ignored.
  assign a_sel = a_edge & ~a_ctl.chip_select_n & a_ctl.enable;
  assign a_wr1 = a_sel & a_ctl.direction & ~a_ctl.mailbox_select
    & fifo1_room;
  assign a_rd2 = a_sel & ~a_ctl.direction & ~a_ctl.mailbox_select
    & (fifo2_count != '0);
  assign a_mail_wr = a_sel & a_ctl.direction & a_ctl.mailbox_select;
  assign a_mail_rd = a_sel & ~a_ctl.direction & a_ctl.mailbox_select;

  assign b_sel = b_edge & ~b_ctl.chip_select_n & b_ctl.enable;
  assign b_rd1 = b_sel & ~b_ctl.mailbox_select & (fifo1_count != '0);
  assign b_done = b_rd1 & (b_piece == last_piece(portb_width_select));
  assign b_mail_rd = b_sel & b_ctl.mailbox_select;

  assign c_sel = c_edge & ~c_ctl.chip_select_n & c_ctl.enable;
  assign c_wr2 = c_sel & ~c_ctl.mailbox_select & fifo2_room;
  assign c_done = c_wr2 & (c_piece == last_piece(portc_width_select));
  assign c_mail_wr = c_sel & c_ctl.mailbox_select;

  // Occupancy is kept in long words; partial pieces do not move it.
  assign fifo1_next = fifo1_count + CW'(a_wr1) - CW'(b_done);
  assign fifo2_next = fifo2_count + CW'(c_done) - CW'(a_rd2);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo1_count <= '0;
      fifo2_count <= '0;
    end else if (core_ce) begin
      fifo1_count <= fifo1_next;
      fifo2_count <= fifo2_next;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      b_piece <= 2'h0;
      c_piece <= 2'h0;
    end else begin
      if (b_rd1) begin
        b_piece <= b_done ? 2'h0 : b_piece + 2'h1;
      end
      if (c_wr2) begin
        c_piece <= c_done ? 2'h0 : c_piece + 2'h1;
      end
    end
  end

  // Flags of a port move only on that port's own clock edge, so a change
  // made by the far port shows at the first local edge after it.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo1_room <= 1'h1;
      porta_almost_empty <= 1'h0;
      porta_almost_full <= 1'h1;
    end else if (a_edge) begin
      fifo1_room <= fifo1_next != CW'(DEPTH);
      porta_almost_empty <= above_ae(fifo2_next);
      porta_almost_full <= below_af(fifo1_next);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      portb_almost_empty <= 1'h0;
    end else if (b_edge) begin
      portb_almost_empty <= above_ae(fifo1_next);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo2_room <= 1'h1;
      portc_almost_full <= 1'h1;
    end else if (c_edge) begin
      fifo2_room <= fifo2_next != CW'(DEPTH);
      portc_almost_full <= below_af(fifo2_next);
    end
  end

  // Ports A and C each have both pins; the mode drives one and holds the other low.
  assign porta_input_ready = fall_through_mode & fifo1_room;
  assign porta_full_flag = ~fall_through_mode & fifo1_room;
  assign portc_input_ready = fall_through_mode & fifo2_room;
  assign portc_full_flag = ~fall_through_mode & fifo2_room;

  logic [`TPFM_MAIL_W-1:0] mailbox_a_to_b, mailbox_c_to_a;

  // New mail wins over a release in the same cycle so it is never lost.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mailbox_a_to_b <= '0;
      mailbox_one_full <= 1'h1;
      portb_data_out <= '0;
    end else begin
      if (b_mail_rd) begin
        mailbox_one_full <= 1'h1;
        portb_data_out <= mailbox_a_to_b;
      end
      if (a_mail_wr) begin
        mailbox_one_full <= 1'h0;
        mailbox_a_to_b <= portb_width_select
          ? {9'h0, a_data[`TPFM_BYTE_W-1:0]}
          : a_data[`TPFM_MAIL_W-1:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mailbox_c_to_a <= '0;
      mailbox_two_full <= 1'h1;
      porta_data_out <= '0;
    end else begin
      if (a_mail_rd) begin
        mailbox_two_full <= 1'h1;
        porta_data_out <= {mailbox_c_to_a, 18'h0};
      end
      if (c_mail_wr) begin
        mailbox_two_full <= 1'h0;
        mailbox_c_to_a <= portc_width_select
          ? {9'h0, c_data[`TPFM_BYTE_W-1:0]}
          : c_data;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      porta_data_oe <= 1'h0;
      portb_data_oe <= 1'h0;
    end else begin
      if (a_edge) begin
        porta_data_oe <= ~a_ctl.chip_select_n & ~a_ctl.direction;
      end
      if (b_edge) begin
        portb_data_oe <= ~b_ctl.chip_select_n;
      end
    end
  end

  // Register bus: address and data may arrive in either order.
  logic aw_got, w_got;
  logic [`TPFM_ADDR_W-1:0] aw_addr;
  logic [`TPFM_DATA_W-1:0] w_data;
  logic [3:0] w_strb;
  logic do_write, wr_ok, wr_low;
  logic [`TPFM_IRQ_W-1:0] irq_clear, irq_set;

  assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
  assign s_axi_wready = ~w_got & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_write = aw_got & w_got & ~s_axi_bvalid;
  assign wr_low = do_write & w_strb[0];
  assign wr_ok = (aw_addr == `TPFM_CTRL_OFS)
    || (aw_addr == `TPFM_IRQ_STAT_OFS) || (aw_addr == `TPFM_IRQ_MASK_OFS);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got <= 1'h0;
      w_got <= 1'h0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'h0;
      s_axi_bresp <= `TPFM_RESP_OKAY;
    end else if (core_ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'h1;
        aw_addr <= {s_axi_awaddr[`TPFM_ADDR_W-1:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'h1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got <= 1'h0;
        w_got <= 1'h0;
        s_axi_bvalid <= 1'h1;
        s_axi_bresp <= wr_ok ? `TPFM_RESP_OKAY : `TPFM_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'h0;
      end
    end
  end

  // Changing size selects mid-stream corrupts piece counting.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `TPFM_CTRL_RST;
      irq_mask <= `TPFM_IRQ_RST;
    end else if (wr_low && core_ce) begin
      if (aw_addr == `TPFM_CTRL_OFS) begin
        ctrl <= w_data[`TPFM_CTRL_W-1:0];
      end
      if (aw_addr == `TPFM_IRQ_MASK_OFS) begin
        irq_mask <= w_data[`TPFM_IRQ_W-1:0];
      end
    end
  end

  assign irq_clear = (wr_low && aw_addr == `TPFM_IRQ_STAT_OFS)
    ? w_data[`TPFM_IRQ_W-1:0] : '0;
  assign irq_set = {c_done && fifo2_next == CW'(DEPTH),
    a_wr1 && fifo1_next == CW'(DEPTH), c_mail_wr, a_mail_wr};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= `TPFM_IRQ_RST;
      irq <= 1'h0;
    end else if (core_ce) begin
      irq_status <= (irq_status & ~irq_clear) | irq_set;
      irq <= |(((irq_status & ~irq_clear) | irq_set) & irq_mask);
    end
  end

  tpfm_flags_t flags;
  logic [`TPFM_DATA_W-1:0] rd_word;
  logic rd_ok;

  assign flags = '{mailbox_two_full, mailbox_one_full, portc_almost_full,
    porta_almost_full, porta_almost_empty, portb_almost_empty,
    fifo2_room, fifo1_room};

  always_comb begin
    rd_word = '0;
    rd_ok = 1'h1;
    unique case ({s_axi_araddr[`TPFM_ADDR_W-1:2], 2'h0})
      `TPFM_CTRL_OFS: rd_word[`TPFM_CTRL_W-1:0] = ctrl;
      `TPFM_STAT_OFS: rd_word[$bits(tpfm_flags_t)-1:0] = flags;
      `TPFM_IRQ_STAT_OFS: rd_word[`TPFM_IRQ_W-1:0] = irq_status;
      `TPFM_IRQ_MASK_OFS: rd_word[`TPFM_IRQ_W-1:0] = irq_mask;
      default: rd_ok = 1'h0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'h0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `TPFM_RESP_OKAY;
    end else if (core_ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'h1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? `TPFM_RESP_OKAY : `TPFM_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'h0;
      end
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_mail_ab_word;
    a_mail_wr && !portb_width_select;
  endsequence

  sequence s_mail_ab_byte;
    a_mail_wr && portb_width_select;
  endsequence

  sequence s_fill_fifo1;
    a_wr1 && fifo1_count == CW'(DEPTH - 1) && !b_done;
  endsequence

  sequence s_fill_fifo2;
    c_done && fifo2_count == CW'(DEPTH - 1) && !a_rd2;
  endsequence

  room_a_edge_a:
    assert property ($rose(fifo1_room) |-> $past(a_edge))
    else $error("port A room flag rose away from a port A edge");
  fifo1_fill_a:
    assert property (s_fill_fifo1 |=> !fifo1_room ##1 fifo1_count ==
      CW'(DEPTH) || !fifo1_room)
    else $error("port A full flag did not fall when FIFO1 filled");
  partial_read_a:
    assert property (b_rd1 && b_piece != last_piece(portb_width_select)
      && !a_wr1 |=> $stable(fifo1_count))
    else $error("partial port B read changed FIFO1 occupancy");
  fifo2_fill_a:
    assert property (s_fill_fifo2 |=> !fifo2_room && !portc_almost_full)
    else $error("port C flags did not fall when FIFO2 filled");
  room_c_edge_a:
    assert property ($rose(fifo2_room) |-> $past(c_edge))
    else $error("port C room flag rose away from a port C edge");
  aeb_edge_a:
    assert property ($changed(portb_almost_empty) |-> $past(b_edge))
    else $error("port B almost-empty moved away from a port B edge");
  mail_ab_word_a:
    assert property (s_mail_ab_word |=>
      mailbox_a_to_b == $past(a_data[`TPFM_MAIL_W-1:0]))
    else $error("word mail from port A took the wrong lanes");
  mail_ab_byte_a:
    assert property (s_mail_ab_byte |=> mailbox_a_to_b[17:9] == 9'h0
      && mailbox_a_to_b[8:0] == $past(a_data[8:0]))
    else $error("byte mail from port A took the wrong lanes");
  mail_ca_lane_a:
    assert property (a_mail_rd |=>
      porta_data_out[35:18] == $past(mailbox_c_to_a)
      && porta_data_out[17:0] == 18'h0)
    else $error("mail to port A not on upper lanes");
  mail_ca_byte_a:
    assert property (c_mail_wr && portc_width_select |=>
      mailbox_c_to_a[17:9] == 9'h0)
    else $error("byte mail from port C kept upper bits");
  mbf_flag_a:
    assert property (a_mail_wr |=> !mailbox_one_full ##1
      (!mailbox_one_full || $past(b_mail_rd)))
    else $error("mailbox one flag wrong after new mail");

endmodule

// ---- testbench/tpfm_port_model.sv ----
`timescale 1ns/1ps
module tpfm_port_model
  import tpfm_pkg::*;
(
  input wire logic core_clk,
  output logic porta_clock,
  output tpfm_porta_ctl_t porta_ctl,
  output logic [35:0] porta_data_in,
  output logic portb_clock,
  output tpfm_port_ctl_t portb_ctl,
  output logic portc_clock,
  output tpfm_port_ctl_t portc_ctl,
  output logic [17:0] portc_data_in
);
  // Port clocks stand still between frames, so a flag that waits for a
  // far edge only moves when that edge is really given.
  initial begin
    {porta_clock, portb_clock, portc_clock} = 3'h0;
    porta_ctl = 4'h8;
    portb_ctl = 3'h4;
    portc_ctl = 3'h4;
    porta_data_in = 36'h0;
    portc_data_in = 18'h0;
  end

  task automatic set_clk(input int p, input logic v);
    case (p)
      0: porta_clock <= v;
      1: portb_clock <= v;
      default: portc_clock <= v;
    endcase
  endtask

  // Pins settle two core cycles before the port edge and hold well past it.
  task automatic cycle(input int p, input logic [3:0] c,
    input logic [35:0] d, input int n);
    repeat (n) begin
      @(posedge core_clk);
      case (p)
        0: porta_ctl <= c;
        1: portb_ctl <= {c[3], c[1:0]};
        default: portc_ctl <= {c[3], c[1:0]};
      endcase
      if (p == 0) porta_data_in <= d;
      if (p == 2) portc_data_in <= d[17:0];
      repeat (2) @(posedge core_clk);
      set_clk(p, 1'b1);
      repeat (4) @(posedge core_clk);
      set_clk(p, 1'b0);
      repeat (1) @(posedge core_clk);
      // Released data pins show the inverse, so a stale value cannot pass.
      porta_ctl <= 4'h8;
      portb_ctl <= 3'h4;
      portc_ctl <= 3'h4;
      porta_data_in <= ~porta_data_in;
      portc_data_in <= ~portc_data_in;
    end
  endtask
endmodule

// ---- testbench/triple_port_fifo_flags_mailbox_bench.sv ----
`timescale 1ns/1ps
`include "tpfm_defines.svh"
module triple_port_fifo_flags_mailbox_bench
  import tpfm_pkg::*;
;
  localparam logic [3:0] A_WR_F = 4'h5;
  localparam logic [3:0] A_RD_F = 4'h1;
  localparam logic [3:0] A_WR_M = 4'h7;
  localparam logic [3:0] A_RD_M = 4'h3;
  localparam logic [3:0] P_FIFO = 4'h1;
  localparam logic [3:0] P_MAIL = 4'h3;
  localparam logic [3:0] P_IDLE = 4'h8;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic core_ce = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq, porta_data_oe, portb_data_oe;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic porta_clock, portb_clock, portc_clock;
  tpfm_porta_ctl_t porta_ctl;
  tpfm_port_ctl_t portb_ctl, portc_ctl;
  logic [35:0] porta_data_in, porta_data_out;
  logic [17:0] portb_data_out, portc_data_in;
  logic porta_input_ready, porta_full_flag, porta_almost_empty;
  logic porta_almost_full, portb_almost_empty, portc_input_ready;
  logic portc_full_flag, portc_almost_full;
  logic mailbox_one_full, mailbox_two_full;
  int failures = 0;
  int checks_done = 0;

  always #12.5 core_clk = ~core_clk;

  tpfm_core #(.DEPTH(4), .AE_OFFSET(1), .AF_OFFSET(1)) dut_u (
    .core_clk, .rst_n, .core_ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .porta_clock,
    .porta_ctl, .porta_data_in, .porta_data_out, .porta_data_oe,
    .porta_input_ready, .porta_full_flag, .porta_almost_empty,
    .porta_almost_full, .portb_clock, .portb_ctl, .portb_data_out,
    .portb_data_oe, .portb_almost_empty, .portc_clock, .portc_ctl,
    .portc_data_in, .portc_input_ready, .portc_full_flag,
    .portc_almost_full, .mailbox_one_full, .mailbox_two_full
  );

  tpfm_port_model pm_u (
    .core_clk, .porta_clock, .porta_ctl, .porta_data_in, .portb_clock,
    .portb_ctl, .portc_clock, .portc_ctl, .portc_data_in
  );

  task automatic end_of_test();
    $display("checks_done %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Values are taken when chk is called; the check then waits for the falling edge.
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    @(negedge core_clk);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic limit(input int n);
    if (n >= 40) begin
      failures++;
      end_of_test();
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw;
    logic w;
    n = 0;
    aw = 1'b1;
    w = 1'b1;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while ((aw || w) && n < 40) begin
      @(negedge core_clk);
      if (s_axi_awready === 1'b1) aw = 1'b0;
      if (s_axi_wready === 1'b1) w = 1'b0;
      @(posedge core_clk);
      if (!aw) s_axi_awvalid <= 1'b0;
      if (!w) s_axi_wvalid <= 1'b0;
      n++;
    end
    do begin
      @(negedge core_clk);
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    limit(n);
    rsp = s_axi_bresp;
    @(posedge core_clk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge core_clk);
      n++;
    end while (s_axi_arready !== 1'b1 && n < 40);
    @(posedge core_clk);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge core_clk);
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    limit(n);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    @(posedge core_clk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask

  initial begin
    do_reset();
    axi_rd(`TPFM_CTRL_OFS);
    chk(rd, 32'h0);
    axi_rd(`TPFM_STAT_OFS);
    chk(rd, 32'hF3);
    axi_rd(8'h10);
    chk(rsp, `TPFM_RESP_SLVERR);
    axi_wr(`TPFM_IRQ_MASK_OFS, 32'h1);
    chk(rsp, `TPFM_RESP_OKAY);
    pm_u.cycle(0, A_WR_M, 36'h8_7654_31A5, 1);
    chk(mailbox_one_full, 1'b0);
    chk(irq, 1'b1);
    pm_u.cycle(1, P_MAIL, 36'h0, 1);
    chk(portb_data_out, 18'h031A5);
    chk(portb_data_oe, 1'b1);
    chk(mailbox_one_full, 1'b1);
    axi_wr(`TPFM_IRQ_STAT_OFS, 32'h1);
    chk(irq, 1'b0);
    pm_u.cycle(2, P_MAIL, 36'h2D5A7, 1);
    chk(mailbox_two_full, 1'b0);
    pm_u.cycle(0, A_RD_M, 36'h0, 1);
    chk(porta_data_out[35:18], 18'h2D5A7);
    chk(porta_data_oe, 1'b1);
    chk(mailbox_two_full, 1'b1);
    pm_u.cycle(0, A_WR_F, 36'h1, 2);
    chk(portb_almost_empty, 1'b0);
    chk(porta_data_oe, 1'b0);
    pm_u.cycle(1, P_IDLE, 36'h0, 2);
    chk(portb_almost_empty, 1'b1);
    chk(portb_data_oe, 1'b0);
    pm_u.cycle(0, A_WR_F, 36'h2, 2);
    chk(porta_full_flag, 1'b0);
    chk(porta_almost_full, 1'b0);
    chk(irq, 1'b0);
    pm_u.cycle(1, P_FIFO, 36'h0, 1);
    pm_u.cycle(0, P_IDLE, 36'h0, 2);
    chk(porta_full_flag, 1'b0);
    pm_u.cycle(1, P_FIFO, 36'h0, 1);
    pm_u.cycle(0, P_IDLE, 36'h0, 2);
    chk(porta_full_flag, 1'b1);
    chk(porta_almost_full, 1'b0);
    pm_u.cycle(1, P_FIFO, 36'h0, 2);
    pm_u.cycle(0, P_IDLE, 36'h0, 2);
    chk(porta_almost_full, 1'b1);
    axi_wr(`TPFM_CTRL_OFS, 32'h1);
    pm_u.cycle(0, A_WR_F, 36'h3, 2);
    chk(porta_input_ready, 1'b0);
    pm_u.cycle(1, P_FIFO, 36'h0, 2);
    pm_u.cycle(0, P_IDLE, 36'h0, 2);
    chk(porta_input_ready, 1'b1);
    pm_u.cycle(1, P_FIFO, 36'h0, 3);
    chk(portb_almost_empty, 1'b1);
    pm_u.cycle(1, P_FIFO, 36'h0, 1);
    chk(portb_almost_empty, 1'b0);
    pm_u.cycle(2, P_FIFO, 36'h5, 7);
    chk(portc_input_ready, 1'b1);
    pm_u.cycle(2, P_FIFO, 36'h6, 1);
    chk(portc_input_ready, 1'b0);
    chk(portc_almost_full, 1'b0);
    chk(porta_almost_empty, 1'b0);
    pm_u.cycle(0, P_IDLE, 36'h0, 2);
    chk(porta_almost_empty, 1'b1);
    pm_u.cycle(0, A_RD_F, 36'h0, 1);
    pm_u.cycle(2, P_IDLE, 36'h0, 2);
    chk(portc_input_ready, 1'b1);
    chk(portc_almost_full, 1'b0);
    pm_u.cycle(0, A_RD_F, 36'h0, 1);
    pm_u.cycle(2, P_IDLE, 36'h0, 2);
    chk(portc_almost_full, 1'b1);
    // Mail C-to-A, FIFO1 full and FIFO2 full are pending; mail A-to-B was
    // cleared by software.
    axi_rd(`TPFM_IRQ_STAT_OFS);
    chk(rd, 32'hE);
    axi_wr(`TPFM_STAT_OFS, 32'h0);
    chk(rsp, `TPFM_RESP_SLVERR);
    // Sizes change only across a reset, never while traffic runs.
    do_reset();
    axi_wr(`TPFM_CTRL_OFS, 32'h6);
    pm_u.cycle(0, A_WR_M, 36'h8_7654_31A5, 1);
    pm_u.cycle(1, P_MAIL, 36'h0, 1);
    chk(portb_data_out[8:0], 9'h1A5);
    pm_u.cycle(2, P_MAIL, 36'h3FE5B, 1);
    pm_u.cycle(0, A_RD_M, 36'h0, 1);
    chk(porta_data_out[26:18], 9'h05B);
    pm_u.cycle(2, P_FIFO, 36'h7, 15);
    chk(portc_full_flag, 1'b1);
    pm_u.cycle(2, P_FIFO, 36'h7, 1);
    chk(portc_full_flag, 1'b0);
    // With the clock enable low a whole port frame is missed, mail included.
    @(posedge core_clk);
    core_ce <= 1'b0;
    pm_u.cycle(0, A_WR_M, 36'h1, 1);
    core_ce <= 1'b1;
    chk(mailbox_one_full, 1'b1);
    end_of_test();
  end
endmodule
